// ### rtl/ctxt_params.svh
// Constants of the continuous transmission test controller.
// Assumes a 100 MHz clock and an 8-bit register port on the transceiver.
`ifndef CTXT_PARAMS_SVH
`define CTXT_PARAMS_SVH
// Transceiver register addresses
`define CTXT_A_IRQ_MASK 8'h0E
`define CTXT_A_CTRL_ONE 8'h04
`define CTXT_A_STATE 8'h02
`define CTXT_A_CHAN 8'h08
`define CTXT_A_PWR 8'h05
`define CTXT_A_STATUS 8'h01
`define CTXT_A_TST 8'h36
`define CTXT_A_CTRL_TWO 8'h0C
`define CTXT_A_RX_CTRL 8'h0A
`define CTXT_A_PART 8'h1C
`define CTXT_A_FB 8'h80
// Values written or expected
`define CTXT_V_MASK 8'h01
`define CTXT_V_CTRL_ONE 8'h00
`define CTXT_V_OFF 8'h03
`define CTXT_V_TST 8'h0F
`define CTXT_V_RATE 8'h03
`define CTXT_V_RX 8'hA7
`define CTXT_V_UNLOCK1 8'h54
`define CTXT_V_UNLOCK2 8'h46
`define CTXT_V_PLL_ON 8'h09
`define CTXT_V_TX_START 8'h02
`define CTXT_V_EXIT 8'h00
`define CTXT_V_OFF_STATUS 5'h08
`define CTXT_V_CW_LOW 8'h00
`define CTXT_V_CW_HIGH 8'hFF
// Software register byte offsets and fields
`define CTXT_R_CTRL 4'h0
`define CTXT_R_CONFIG 4'h4
`define CTXT_R_STATUS 4'h8
`define CTXT_R_FBDATA 4'hC
`define CTXT_F_START 0
`define CTXT_F_CW 1
`define CTXT_F_CHAN 2
`define CTXT_F_PWR 3
`define CTXT_F_STOP 4
// Transceiver reset pulse and frame buffer FIFO size
`define CTXT_RST_NS 1000
`define CTXT_CLK_MHZ 100
`define CTXT_RST_CYC ((`CTXT_RST_NS * `CTXT_CLK_MHZ + 999) / 1000)
`define CTXT_FIFO_DEPTH 4
`define CTXT_FIFO_WIDTH 8
`endif

// ### rtl/ctxt_pkg.sv
// Types of the continuous transmission test controller.
// Assumes nothing of its surroundings.
package ctxt_pkg;
   typedef enum logic [4:0] {
      S_IDLE = 5'b00000, S_RST = 5'b00001, S_MASK = 5'b00010, S_CTRL1 = 5'b00011,
      S_OFF = 5'b00100, S_CHAN = 5'b00101, S_PWR = 5'b00110, S_CHK = 5'b00111,
      S_TST = 5'b01000, S_RATE = 5'b01001, S_RX = 5'b01010, S_FB = 5'b01011,
      S_UNL1 = 5'b01100, S_UNL2 = 5'b01101, S_PLL = 5'b01110, S_LOCK = 5'b01111,
      S_TXGO = 5'b10000, S_ACTIVE = 5'b10001, S_EXIT = 5'b10010, S_RST2 = 5'b10011
   } ctxt_state_t;
   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] data;
   } ctxt_step_t;
endpackage

// ### rtl/ctxt_ctrl.sv
// Controller that runs the transceiver's continuous transmission test sequence.
// Assumes the transceiver register port answers on this clock with a one-cycle
// ack, and that the lock interrupt arrives asynchronously.
//
// Overview of operation
// - All configuration is written before the test mode is unlocked.
// - Unlock is 0x0F to digital test control, then 0x54 and 0x46 to part id.
// - Transmission starts with 0x09 then 0x02 to the state command register.
// - The frame buffer is loaded before starting, even for a tone.
// - The first frame byte is the length and equals the bytes that follow.
// - A random pattern of maximum length is advised for modulated output.
// - For a tone every data byte is 0x00 or every byte is 0xFF.
// - After reset the interrupt mask gets 0x01, the lock interrupt only.
// - The off state 0x03 is written before configuring and checked after channel and power.
// - Only tone mode writes 0x03 to control two and 0xA7 to receive control.
// - Transmit start waits for the lock interrupt after the 0x09 write.
// - Writing 0x00 to part id leaves the test mode, then a reset follows.
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "ctxt_params.svh"

module ctxt_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } ctxt_fifo_t;
   ctxt_fifo_t r, n;
   logic push, pop;

   assign in_ready = (r.cnt != (AW+1)'(D));
   assign out_valid = (r.cnt != '0);
   assign out_data = r.mem[r.rp];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      n = r;
      if (push) begin
         n.mem[r.wp] = in_data;
         n.wp = (r.wp == AW'(D - 1)) ? '0 : r.wp + 1'b1;
      end
      if (pop) begin
         n.rp = (r.rp == AW'(D - 1)) ? '0 : r.rp + 1'b1;
      end
      n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule

module ctxt_ctrl import ctxt_pkg::*; (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic trx_rst_b,
   output logic trx_req,
   output logic trx_we,
   output logic [7:0] trx_addr,
   output logic [7:0] trx_wdata,
   input wire logic trx_ack,
   input wire logic [7:0] trx_rdata,
   input wire logic trx_irq_lock
);
   typedef struct packed {
      ctxt_state_t st;
      logic req;
      logic we;
      logic [7:0] addr;
      logic [7:0] data;
      logic rst_n;
      logic [7:0] cnt;
      logic [7:0] fb_left;
      logic fb_len_seen;
      logic [7:0] fb_prev;
      logic fb_any;
      logic cw;
      logic chan_en;
      logic pwr_en;
      logic [7:0] chan;
      logic [7:0] pwr;
      logic err;
      logic cw_bad;
      logic stop_req;
      logic irq_s1;
      logic irq_s2;
      logic rvalid;
      logic [31:0] rdata;
      logic h_unl0;
      logic h_lock;
      logic h_fb_done;
      logic [15:0] h_last;
   } ctxt_regs_t;
   ctxt_regs_t r, n;
   logic fb_valid, fb_ready, fb_in_ready, fb_push, rd, acc;
   logic [7:0] fb_data;

   function automatic ctxt_step_t step_of(input ctxt_state_t s, input logic [7:0] ch,
                                          input logic [7:0] pw);
      case (s)
         S_MASK: step_of = '{1'b1, `CTXT_A_IRQ_MASK, `CTXT_V_MASK};
         S_CTRL1: step_of = '{1'b1, `CTXT_A_CTRL_ONE, `CTXT_V_CTRL_ONE};
         S_OFF: step_of = '{1'b1, `CTXT_A_STATE, `CTXT_V_OFF};
         S_CHAN: step_of = '{1'b1, `CTXT_A_CHAN, ch};
         S_PWR: step_of = '{1'b1, `CTXT_A_PWR, pw};
         S_CHK: step_of = '{1'b0, `CTXT_A_STATUS, 8'h00};
         S_TST: step_of = '{1'b1, `CTXT_A_TST, `CTXT_V_TST};
         S_RATE: step_of = '{1'b1, `CTXT_A_CTRL_TWO, `CTXT_V_RATE};
         S_RX: step_of = '{1'b1, `CTXT_A_RX_CTRL, `CTXT_V_RX};
         S_UNL1: step_of = '{1'b1, `CTXT_A_PART, `CTXT_V_UNLOCK1};
         S_UNL2: step_of = '{1'b1, `CTXT_A_PART, `CTXT_V_UNLOCK2};
         S_PLL: step_of = '{1'b1, `CTXT_A_STATE, `CTXT_V_PLL_ON};
         S_TXGO: step_of = '{1'b1, `CTXT_A_STATE, `CTXT_V_TX_START};
         S_EXIT: step_of = '{1'b1, `CTXT_A_PART, `CTXT_V_EXIT};
         default: step_of = '{1'b0, 8'h00, 8'h00};
      endcase
   endfunction

   function automatic ctxt_state_t next_of(input ctxt_state_t s, input logic cw,
                                           input logic ch_en, input logic pw_en);
      case (s)
         S_MASK: next_of = S_CTRL1;
         S_CTRL1: next_of = S_OFF;
         S_OFF: next_of = ch_en ? S_CHAN : (pw_en ? S_PWR : S_CHK);
         S_CHAN: next_of = pw_en ? S_PWR : S_CHK;
         S_PWR: next_of = S_CHK;
         S_CHK: next_of = S_TST;
         S_TST: next_of = cw ? S_RATE : S_FB;
         S_RATE: next_of = S_RX;
         S_RX: next_of = S_FB;
         S_FB: next_of = S_UNL1;
         S_UNL1: next_of = S_UNL2;
         S_UNL2: next_of = S_PLL;
         S_PLL: next_of = S_LOCK;
         S_TXGO: next_of = S_ACTIVE;
         S_EXIT: next_of = S_RST2;
         default: next_of = S_IDLE;
      endcase
   endfunction

   assign fb_push = avs_write & (avs_address == `CTXT_R_FBDATA);
   assign rd = avs_read & ~r.rvalid;
   assign avs_waitrequest = rd | (fb_push & ~fb_in_ready);
   assign avs_readdata = r.rdata;
   assign trx_rst_b = r.rst_n;
   assign trx_req = r.req;
   assign trx_we = r.we;
   assign trx_addr = r.addr;
   assign trx_wdata = r.data;
   assign acc = r.req & trx_ack;
   assign fb_ready = (r.st == S_FB) & ~r.req;

   ctxt_fifo #(.W(`CTXT_FIFO_WIDTH), .D(`CTXT_FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst_b(rst_b),
      .in_valid(fb_push),
      .in_ready(fb_in_ready),
      .in_data(avs_writedata[7:0]),
      .out_valid(fb_valid),
      .out_ready(fb_ready),
      .out_data(fb_data)
   );

   always_comb begin
      n = r;
      n.irq_s1 = trx_irq_lock;
      n.irq_s2 = r.irq_s1;
      n.rvalid = rd;
      if (rd) begin
         case (avs_address)
            `CTXT_R_CTRL: n.rdata = {29'h0000_0000, r.pwr_en, r.chan_en, r.cw};
            `CTXT_R_CONFIG: n.rdata = {16'h0000, r.pwr, r.chan};
            `CTXT_R_STATUS: n.rdata = {22'h00_0000, r.st == S_ACTIVE, r.st != S_IDLE,
                                       r.cw_bad, r.err, 1'b0, r.st};
            default: n.rdata = 32'h0000_0000;
         endcase
      end
      if (avs_write && avs_address == `CTXT_R_CTRL) begin
         if (avs_writedata[`CTXT_F_STOP]) begin
            n.stop_req = 1'b1;
         end
         if (avs_writedata[`CTXT_F_START] && r.st == S_IDLE) begin
            // Configuration is fixed before anything reaches the transceiver
            n.cw = avs_writedata[`CTXT_F_CW];
            n.chan_en = avs_writedata[`CTXT_F_CHAN];
            n.pwr_en = avs_writedata[`CTXT_F_PWR];
            n.err = 1'b0;
            n.cw_bad = 1'b0;
            n.stop_req = 1'b0;
            n.fb_len_seen = 1'b0;
            n.fb_any = 1'b0;
            n.h_unl0 = 1'b0;
            n.h_lock = 1'b0;
            n.h_fb_done = 1'b0;
            n.cnt = 8'h00;
            n.st = S_RST;
         end
      end
      if (avs_write && avs_address == `CTXT_R_CONFIG && r.st == S_IDLE) begin
         n.chan = avs_writedata[7:0];
         n.pwr = avs_writedata[15:8];
      end
      if (acc) begin
         n.h_last = {r.addr, r.data};
      end
      case (r.st)
         S_IDLE: begin
            n.rst_n = 1'b1;
         end
         S_RST, S_RST2: begin
            // Transceiver reset at both ends of the sequence
            n.rst_n = 1'b0;
            n.cnt = r.cnt + 8'h01;
            // Low for exactly the reset count: the first low edge leaves the count at one
            if (r.cnt == 8'(`CTXT_RST_CYC)) begin
               n.rst_n = 1'b1;
               n.cnt = 8'h00;
               n.st = (r.st == S_RST) ? S_MASK : S_IDLE;
            end
         end
         S_LOCK: begin
            if (r.irq_s2) begin
               n.h_lock = 1'b1;
               n.st = S_TXGO;
            end
         end
         S_ACTIVE: begin
            // Transceiver repeats the PSDU until told to leave
            // Stop stays set until the next start, so a stop written after the start never gets lost
            if (r.stop_req) begin
               n.st = S_EXIT;
            end
         end
         S_FB: begin
            if (!r.req && fb_valid) begin
               n.req = 1'b1;
               n.we = 1'b1;
               n.addr = `CTXT_A_FB;
               n.data = fb_data;
               if (!r.fb_len_seen) begin
                  n.fb_left = fb_data;
                  n.fb_len_seen = 1'b1;
               end else begin
                  n.fb_left = r.fb_left - 8'h01;
                  n.fb_prev = fb_data;
                  n.fb_any = 1'b1;
                  // A tone needs a uniform pattern of zeros or ones
                  if (r.cw && ((fb_data != `CTXT_V_CW_LOW && fb_data != `CTXT_V_CW_HIGH)
                               || (r.fb_any && fb_data != r.fb_prev))) begin
                     n.cw_bad = 1'b1;
                  end
               end
            end
            if (acc) begin
               n.req = 1'b0;
               if (r.fb_len_seen && r.fb_left == 8'h00) begin
                  n.h_fb_done = 1'b1;
                  // Buffer loaded before unlock, a bad tone pattern aborts
                  n.st = (r.cw_bad || (r.cw && !r.fb_any)) ? S_RST2 : S_UNL1;
                  n.err = r.cw_bad || (r.cw && !r.fb_any);
               end
            end
         end
         S_MASK, S_CTRL1, S_OFF, S_CHAN, S_PWR, S_CHK, S_TST, S_RATE, S_RX,
         S_UNL1, S_UNL2, S_PLL, S_TXGO, S_EXIT: begin
            // Fixed ordered steps
            if (!r.req) begin
               n.req = 1'b1;
               {n.we, n.addr, n.data} = step_of(r.st, r.chan, r.pwr);
            end else if (trx_ack) begin
               n.req = 1'b0;
               n.st = next_of(r.st, r.cw, r.chan_en, r.pwr_en);
               if (r.st == S_TST) begin
                  n.h_unl0 = 1'b1;
               end
               if (r.st == S_CHK && trx_rdata[4:0] != `CTXT_V_OFF_STATUS) begin
                  n.err = 1'b1;
                  n.st = S_RST2;
               end
            end
         end
         default: n.st = S_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   logic accw;
   assign accw = acc & r.we;

   a_unlock_first: assert property (
      accw && r.addr == `CTXT_A_PART && r.data == `CTXT_V_UNLOCK1 |-> r.h_unl0)
      else $error("Part id unlock written before digital test control");
   a_unlock_order: assert property (
      accw && r.addr == `CTXT_A_PART && r.data == `CTXT_V_UNLOCK2
      |-> r.h_last == {`CTXT_A_PART, `CTXT_V_UNLOCK1})
      else $error("Second unlock value not preceded by first");
   a_pll_before_tx: assert property (
      accw && r.addr == `CTXT_A_STATE && r.data == `CTXT_V_TX_START
      |-> r.h_lock && r.h_last == {`CTXT_A_STATE, `CTXT_V_PLL_ON})
      else $error("Transmit start without lock after synthesizer on");
   a_lock_to_start: assert property (
      r.st == S_LOCK && r.irq_s2 |=> r.st == S_TXGO ##1 trx_req && trx_addr == `CTXT_A_STATE)
      else $error("Lock interrupt did not lead to transmit start");
   a_rate_cw_only: assert property (
      trx_req && (trx_addr == `CTXT_A_CTRL_TWO || trx_addr == `CTXT_A_RX_CTRL) |-> r.cw)
      else $error("Rate setting written in modulated mode");
   a_mask_value: assert property (
      trx_req && trx_addr == `CTXT_A_IRQ_MASK |-> trx_wdata == `CTXT_V_MASK && $past(r.st) != S_IDLE)
      else $error("Interrupt mask written with wrong value");
   a_off_checked: assert property (
      accw && r.addr == `CTXT_A_TST |-> r.h_last[15:8] == `CTXT_A_STATUS)
      else $error("Test control written without status check");
   a_buffer_loaded: assert property (
      trx_req && trx_addr == `CTXT_A_PART && trx_wdata == `CTXT_V_UNLOCK1 |-> r.h_fb_done)
      else $error("Unlock before frame buffer loaded");
   a_length_match: assert property (
      $rose(r.h_fb_done) |-> $past(r.st) == S_FB && r.fb_left == 8'h00 && r.fb_len_seen)
      else $error("Frame length does not match pattern");
   a_exit_reset: assert property (
      accw && r.addr == `CTXT_A_PART && r.data == `CTXT_V_EXIT |-> ##[1:2] !trx_rst_b)
      else $error("No transceiver reset after leaving test mode");
   a_ctrl_one_zero: assert property (
      trx_req && trx_addr == `CTXT_A_CTRL_ONE |-> trx_wdata == `CTXT_V_CTRL_ONE && !r.h_fb_done)
      else $error("Control one not cleared before buffer load");
   a_tone_uniform: assert property (
      r.st == S_UNL1 |-> !(r.cw && r.cw_bad))
      else $error("Unlock reached with non uniform tone pattern");

   c_modulated_run: cover property (r.st == S_ACTIVE && !r.cw);
   c_tone_run: cover property (r.st == S_ACTIVE && r.cw);
   c_status_fail: cover property (r.st == S_CHK && acc && trx_rdata[4:0] != `CTXT_V_OFF_STATUS);
   c_fifo_full: cover property (fb_push && !fb_in_ready);
endmodule

// ### tb/ctxt_trx_model.sv
// Behavioural transceiver register port for the test controller bench.
// Assumes the controller holds each request until it sees the ack pulse.
`timescale 1ns/1ps
`include "ctxt_params.svh"
module ctxt_trx_model #(
   parameter int LOCK_DLY = 20
) (
   input wire logic clock,
   input wire logic trx_rst_b,
   input wire logic trx_req,
   input wire logic trx_we,
   input wire logic [7:0] trx_addr,
   input wire logic [7:0] trx_wdata,
   output logic trx_ack,
   output logic [7:0] trx_rdata,
   output logic trx_irq_lock
);
   int slow = 0;
   bit bad_status = 0;
   int viol = 0;
   int tone = 0;
   logic [16:0] log[$];
   int wcnt, stage, lk, age, fb_n;
   bit done, off, all0, all1;
   logic [7:0] fb_len, d;
   initial trx_rdata = 8'h00;
   task access;
      d = trx_wdata;
      if (!trx_we) begin
         d = (trx_addr == `CTXT_A_STATUS && off && !bad_status) ? 8'h08 : 8'h00;
         trx_rdata <= d;
         log.push_back({1'b0, trx_addr, d});
      end else begin
         log.push_back({1'b1, trx_addr, d});
         case (trx_addr)
            `CTXT_A_STATE: begin
               if (d == 8'h03) off = 1;
               if (d == 8'h09) begin
                  if (stage != 3) viol++;
                  lk = 1;
               end
               if (d == 8'h02) begin
                  if (age < 2 || stage != 3) viol++;
                  tone = all0 ? -1 : (all1 ? 1 : 0);
               end
            end
            `CTXT_A_TST: if (d == 8'h0F) stage = 1;
            `CTXT_A_PART: begin
               if (d == 8'h00) stage = 0;
               else if (d == 8'h54 && stage == 1 && fb_n == fb_len + 1) stage = 2;
               else if (d == 8'h46 && stage == 2) stage = 3;
               else viol++;
            end
            `CTXT_A_FB: begin
               if (fb_n == 0) fb_len = d;
               else begin
                  all0 &= (d == 8'h00);
                  all1 &= (d == 8'hFF);
               end
               fb_n++;
            end
            default: ;
         endcase
      end
   endtask
   always @(posedge clock or negedge trx_rst_b) begin
      trx_ack <= 1'b0;
      trx_rdata <= ~trx_rdata;
      if (!trx_rst_b) begin
         trx_irq_lock <= 1'b0;
         done = 0; wcnt = 0; stage = 0; lk = 0; age = 0; fb_n = 0;
         off = 0; all0 = 1; all1 = 1;
      end else begin
         if (lk > 0 && lk < LOCK_DLY) lk++;
         trx_irq_lock <= (lk >= LOCK_DLY);
         if (trx_irq_lock) age++;
         if (!trx_req) begin
            done = 0; wcnt = 0;
         end else if (!done && wcnt < slow) wcnt++;
         else if (!done) begin
            done = 1;
            trx_ack <= 1'b1;
            access();
         end
      end
   end
endmodule

// ### tb/ctxt_ctrl_tb.sv
// Self-checking bench for the continuous transmission test controller.
// Assumes the controller, its FIFO and the transceiver model are compiled first.
`timescale 1ns/1ps
`include "ctxt_params.svh"
module ctxt_ctrl_tb;
   logic clock, rst_b, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic trx_rst_b, trx_req, trx_we, trx_ack, trx_irq_lock;
   logic [7:0] trx_addr, trx_wdata, trx_rdata;
   int failures = 0, num_checks = 0, cyc = 0, low_n = 0, last_low = 0, i, n;
   logic [16:0] exp[$];
   typedef struct {bit cw, ch, pw; logic [7:0] chan, pwr, len; int kind, slow; bit err;} ctxt_row_t;
   ctxt_row_t rows[5] = '{'{0, 0, 0, 8'h00, 8'h00, 8'h04, 0, 0, 0},
      '{0, 1, 1, 8'h33, 8'h00, 8'h06, 0, 3, 0}, '{1, 1, 0, 8'h2B, 8'h00, 8'h03, 1, 1, 0},
      '{1, 0, 1, 8'h00, 8'h07, 8'h05, 2, 0, 0}, '{1, 0, 0, 8'h00, 8'h00, 8'h03, 3, 0, 1}};
   ctxt_ctrl u_ctxt_ctrl (.clock(clock), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trx_rst_b(trx_rst_b),
      .trx_req(trx_req), .trx_we(trx_we), .trx_addr(trx_addr), .trx_wdata(trx_wdata),
      .trx_ack(trx_ack), .trx_rdata(trx_rdata), .trx_irq_lock(trx_irq_lock));
   ctxt_trx_model u_ctxt_trx_model (.clock(clock), .trx_rst_b(trx_rst_b), .trx_req(trx_req),
      .trx_we(trx_we), .trx_addr(trx_addr), .trx_wdata(trx_wdata), .trx_ack(trx_ack),
      .trx_rdata(trx_rdata), .trx_irq_lock(trx_irq_lock));
   initial begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   task summarize;
      if (failures == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (!trx_rst_b) low_n++;
      else if (low_n != 0) begin
         last_low = low_n;
         low_n = 0;
      end
      if (cyc == 60000) begin
         failures++;
         summarize();
      end
   end
   task chk(input string what, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic av_cycle(input logic [3:0] a, input logic [31:0] d, input bit wr);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wait_status(input int b, input logic v);
      for (int k = 0; k < 3000; k++) begin
         av_cycle(`CTXT_R_STATUS, 32'h0000_0000, 0);
         if (rd[b] === v) break;
      end
   endtask
   function automatic logic [7:0] fb_byte(input int kind, input int j);
      case (kind)
         0: return 8'h5A ^ (8'(j) * 8'h1D);
         1: return 8'h00;
         2: return 8'hFF;
         default: return j[0] ? 8'hFF : 8'h00;
      endcase
   endfunction
   function automatic int count_addr(input logic [7:0] a);
      int c = 0;
      foreach (u_ctxt_trx_model.log[k]) if (u_ctxt_trx_model.log[k][15:8] == a) c++;
      return c;
   endfunction
   task automatic run_row(input ctxt_row_t w);
      u_ctxt_trx_model.slow = w.slow;
      u_ctxt_trx_model.log.delete();
      av_cycle(`CTXT_R_CONFIG, {16'h0000, w.pwr, w.chan}, 1);
      av_cycle(`CTXT_R_CTRL, {28'h000_0000, w.pw, w.ch, w.cw, 1'b1}, 1);
      av_cycle(`CTXT_R_CTRL, 32'h0000_0000, 0);
      chk("ctrl readback", {29'h0000_0000, w.pw, w.ch, w.cw}, rd);
      av_cycle(`CTXT_R_FBDATA, {24'h00_0000, w.len}, 1);
      for (i = 0; i < w.len; i++) av_cycle(`CTXT_R_FBDATA, {24'h00_0000, fb_byte(w.kind, i)}, 1);
      if (w.err) begin
         wait_status(8, 1'b0);
         chk("pattern error", 32'h0000_0001, rd[6]);
         chk("unlock count", 32'h0000_0000, count_addr(`CTXT_A_PART));
      end else begin
         wait_status(9, 1'b1);
         exp = '{{1'b1, 8'h0E, 8'h01}, {1'b1, 8'h04, 8'h00}, {1'b1, 8'h02, 8'h03}};
         if (w.ch) exp.push_back({1'b1, 8'h08, w.chan});
         if (w.pw) exp.push_back({1'b1, 8'h05, w.pwr});
         exp.push_back({1'b0, 8'h01, 8'h08});
         exp.push_back({1'b1, 8'h36, 8'h0F});
         if (w.cw) exp.push_back({1'b1, 8'h0C, 8'h03});
         if (w.cw) exp.push_back({1'b1, 8'h0A, 8'hA7});
         exp.push_back({1'b1, 8'h80, w.len});
         for (i = 0; i < w.len; i++) exp.push_back({1'b1, 8'h80, fb_byte(w.kind, i)});
         exp.push_back({1'b1, 8'h1C, 8'h54});
         exp.push_back({1'b1, 8'h1C, 8'h46});
         exp.push_back({1'b1, 8'h02, 8'h09});
         exp.push_back({1'b1, 8'h02, 8'h02});
         n = u_ctxt_trx_model.log.size();
         chk("access count", exp.size(), n);
         foreach (exp[k]) chk("access", exp[k], k < n ? u_ctxt_trx_model.log[k] : 17'bx);
         if (w.cw) chk("tone side", w.kind == 1 ? -1 : 1, u_ctxt_trx_model.tone);
         av_cycle(`CTXT_R_CTRL, 32'h0000_0010, 1);
         wait_status(8, 1'b0);
         chk("exit write", {1'b1, 8'h1C, 8'h00}, u_ctxt_trx_model.log[$]);
      end
      repeat (3) @(posedge clock);
      chk("reset pulse", `CTXT_RST_CYC, last_low);
      chk("model order", 0, u_ctxt_trx_model.viol);
   endtask
   initial begin
      rst_b = 0;
      avs_address = 4'h0;
      avs_read = 0;
      avs_write = 0;
      avs_writedata = 32'h0000_0000;
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      foreach (rows[r]) run_row(rows[r]);
      // Status read does not show off state: no test mode entry
      u_ctxt_trx_model.bad_status = 1;
      u_ctxt_trx_model.log.delete();
      av_cycle(`CTXT_R_CTRL, 32'h0000_0001, 1);
      wait_status(8, 1'b0);
      chk("status error", 32'h0000_0001, rd[6]);
      chk("test write count", 32'h0000_0000, count_addr(`CTXT_A_TST));
      u_ctxt_trx_model.bad_status = 0;
      // Reset while transmitting
      av_cycle(`CTXT_R_CTRL, 32'h0000_0001, 1);
      av_cycle(`CTXT_R_FBDATA, 32'h0000_0001, 1);
      av_cycle(`CTXT_R_FBDATA, 32'h0000_00C3, 1);
      wait_status(9, 1'b1);
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      chk("trx reset held", 32'h0000_0000, trx_rst_b);
      chk("trx request idle", 32'h0000_0000, trx_req);
      rst_b <= 1'b1;
      av_cycle(`CTXT_R_CTRL, 32'h0000_0000, 0);
      chk("ctrl after reset", 32'h0000_0000, rd);
      av_cycle(4'h2, 32'h0000_0000, 0);
      chk("unmapped read", 32'h0000_0000, rd);
      av_cycle(`CTXT_R_STATUS, 32'h0000_0000, 0);
      chk("busy after reset", 32'h0000_0000, rd[8]);
      summarize();
   end
endmodule
